// file: core/cpu_dual_pointer_sfr.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_dual_pointer_sfr
  import sfr_timing_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic op_start,
  input wire logic [2:0] op_bytes,
  input wire logic op_class_ext,
  input wire logic op_class_prod,
  output logic [7:0] sfr_rdata,
  output logic [15:0] data_pointer,
  output logic op_done,
  output logic op_busy,
  output logic [2:0] timer_tick_out
);

  logic [7:0] port_zero_latch_r;
  logic [7:0] stack_top_pointer_r;
  logic [7:0] pointer_a_low_r;
  logic [7:0] pointer_a_high_r;
  logic [7:0] pointer_b_low_r;
  logic [7:0] pointer_b_high_r;
  logic [7:0] pointer_select_r;
  logic [7:0] power_control_r;
  logic [7:0] timer_control_r;
  logic [7:0] timer_mode_r;
  logic [7:0] timer_zero_low_r;
  logic [7:0] timer_one_low_r;
  logic [7:0] clock_control_r;
  logic [7:0] rdata_nxt;
  logic [15:0] first_pointer;
  logic [15:0] second_pointer;
  logic [7:0] pointer_select_nxt;
  logic [7:0] power_control_nxt;
  logic cycle_end;
  logic [2:0] tick_w;
  logic [2:0] need_nxt;
  logic [2:0] need_r;
  logic [2:0] done_cnt_r;
  logic [2:0] done_cnt_nxt;
  logic [3:0] ext_cycles;
  op_class_t op_class;
  logic busy_nxt;
  logic finish;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = sfr_wr && (a == target);
  endfunction

  assign first_pointer = {pointer_a_high_r, pointer_a_low_r};
  assign second_pointer = {pointer_b_high_r, pointer_b_low_r};

  // The select register is written through the keep mask, so an increment from
  // 0x00 or 0x01 lands on 0x01 or 0x00 and flips the choice in one instruction.
  assign pointer_select_nxt = sfr_wdata & pointer_select_keep;
  assign power_control_nxt = (sfr_wdata & power_control_keep) | power_control_fixed;

  always_comb begin
    unique case (sfr_addr)
      port_zero_latch_addr: rdata_nxt = port_zero_latch_r;
      stack_top_pointer_addr: rdata_nxt = stack_top_pointer_r;
      pointer_a_low_addr: rdata_nxt = pointer_a_low_r;
      pointer_a_high_addr: rdata_nxt = pointer_a_high_r;
      pointer_b_low_addr: rdata_nxt = pointer_b_low_r;
      pointer_b_high_addr: rdata_nxt = pointer_b_high_r;
      pointer_select_addr: rdata_nxt = pointer_select_r;
      power_control_addr: rdata_nxt = power_control_r;
      timer_control_addr: rdata_nxt = timer_control_r;
      timer_mode_addr: rdata_nxt = timer_mode_r;
      timer_zero_low_addr: rdata_nxt = timer_zero_low_r;
      timer_one_low_addr: rdata_nxt = timer_one_low_r;
      clock_control_addr: rdata_nxt = clock_control_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Power-on and watchdog reset both arrive on rst_n.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_zero_latch_r <= port_zero_latch_rst;
      stack_top_pointer_r <= stack_top_pointer_rst;
      pointer_a_low_r <= pointer_rst;
      pointer_a_high_r <= pointer_rst;
      pointer_b_low_r <= pointer_rst;
      pointer_b_high_r <= pointer_rst;
      pointer_select_r <= pointer_select_rst;
      power_control_r <= power_control_rst;
      timer_control_r <= timer_control_rst;
      timer_mode_r <= timer_mode_rst;
      timer_zero_low_r <= timer_low_rst;
      timer_one_low_r <= timer_low_rst;
      clock_control_r <= clock_control_rst;
    end else begin
      if (hit(sfr_addr, port_zero_latch_addr)) port_zero_latch_r <= sfr_wdata;
      if (hit(sfr_addr, stack_top_pointer_addr)) stack_top_pointer_r <= sfr_wdata;
      if (hit(sfr_addr, pointer_a_low_addr)) pointer_a_low_r <= sfr_wdata;
      if (hit(sfr_addr, pointer_a_high_addr)) pointer_a_high_r <= sfr_wdata;
      if (hit(sfr_addr, pointer_b_low_addr)) pointer_b_low_r <= sfr_wdata;
      if (hit(sfr_addr, pointer_b_high_addr)) pointer_b_high_r <= sfr_wdata;
      if (hit(sfr_addr, pointer_select_addr)) pointer_select_r <= pointer_select_nxt;
      if (hit(sfr_addr, power_control_addr)) power_control_r <= power_control_nxt;
      if (hit(sfr_addr, timer_control_addr)) timer_control_r <= sfr_wdata;
      if (hit(sfr_addr, timer_mode_addr)) timer_mode_r <= sfr_wdata;
      if (hit(sfr_addr, timer_zero_low_addr)) timer_zero_low_r <= sfr_wdata;
      if (hit(sfr_addr, timer_one_low_addr)) timer_one_low_r <= sfr_wdata;
      // Bits 7 and 6 are spare storage with no effect anywhere.
      if (hit(sfr_addr, clock_control_addr)) clock_control_r <= sfr_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
      data_pointer <= 16'h0000;
    end else begin
      if (sfr_rd) sfr_rdata <= rdata_nxt;
      // A pointer write takes effect on data_pointer one clock later.
      data_pointer <= pointer_select_r[0] ? second_pointer : first_pointer;
    end
  end

  phase_counter u_phase (
    .mclk(mclk),
    .rst_n(rst_n),
    .cycle_end(cycle_end)
  );

  genvar gi;
  generate
    for (gi = 0; gi < timer_count; gi++) begin : g_tick
      timer_tick u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .fast(clock_control_r[timer0_speed_bit + gi]),
        .tick(tick_w[gi])
      );
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) timer_tick_out <= 3'h0;
    else timer_tick_out <= tick_w;
  end

  // Cycle budget per instruction. Stretch values above three are clamped so
  // every instruction stays inside the five-cycle ceiling.
  assign op_class = op_class_prod ? op_product : (op_class_ext ? op_external_move : op_plain);
  assign ext_cycles = 4'(ext_move_base_cycles) + {1'b0, clock_control_r[2:0]};
  always_comb begin
    unique case (op_class)
      op_external_move: need_nxt = (ext_cycles > 4'(max_instr_cycles)) ?
                                   3'(max_instr_cycles) : ext_cycles[2:0];
      op_product: need_nxt = 3'(product_cycles);
      default: need_nxt = (op_bytes < 3'(min_instr_cycles)) ? 3'(min_instr_cycles) :
                          (op_bytes > 3'(max_instr_cycles)) ? 3'(max_instr_cycles) :
                          op_bytes;
    endcase
  end

  assign finish = op_busy && cycle_end && (done_cnt_r + 3'h1 == need_r);
  assign busy_nxt = op_busy ? !finish : (op_start && cycle_end);
  assign done_cnt_nxt = (!op_busy || finish) ? 3'h0 : (cycle_end ? done_cnt_r + 3'h1 : done_cnt_r);

  // Instructions start on a cycle boundary, so each runs whole four-clock cycles.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_busy <= 1'b0;
      op_done <= 1'b0;
      need_r <= 3'h1;
      done_cnt_r <= 3'h0;
    end else begin
      op_busy <= busy_nxt;
      op_done <= finish;
      done_cnt_r <= done_cnt_nxt;
      if (!op_busy && op_start && cycle_end) need_r <= need_nxt;
    end
  end

  a_select_low_only: assert property (@(posedge mclk) disable iff (!rst_n)
    pointer_select_r[7:1] == 7'h00)
    else $error("select register upper bits not zero");

  a_select_picks_pointer: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 data_pointer == ($past(pointer_select_r[0]) ? $past(second_pointer) :
    $past(first_pointer)))
    else $error("active pointer does not follow select bit");

  a_select_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_wr && sfr_addr == pointer_select_addr && sfr_wdata == pointer_select_r + 8'h01
    |=> pointer_select_r[0] != $past(pointer_select_r[0]))
    else $error("increment did not toggle pointer choice");

  a_fixed_bits_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    power_control_r[5:4] == 2'b11)
    else $error("fixed power control bits changed");

  a_first_pointer_map: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_wr && sfr_addr == pointer_a_low_addr |=> pointer_a_low_r == $past(sfr_wdata))
    else $error("first pointer low byte not written");

  a_second_pointer_map: assert property (@(posedge mclk) disable iff (!rst_n)
    sfr_wr && sfr_addr == pointer_b_high_addr |=> pointer_b_high_r == $past(sfr_wdata))
    else $error("second pointer high byte not written");

  a_ext_move_len: assert property (@(posedge mclk) disable iff (!rst_n)
    !op_busy && op_start && cycle_end && op_class_ext && !op_class_prod
    && clock_control_r[2:0] == 3'h0 |=> op_busy [*8] ##1 !op_busy)
    else $error("pointer read not eight clocks");

  a_direct_move_len: assert property (@(posedge mclk) disable iff (!rst_n)
    !op_busy && op_start && cycle_end && !op_class_ext && !op_class_prod
    && op_bytes == 3'h3 |=> op_busy [*8] ##1 op_busy [*4]
    ##1 !op_busy)
    else $error("direct move not twelve clocks");

  a_reset_values: assert property (@(posedge mclk)
    $rose(rst_n) |-> stack_top_pointer_r == stack_top_pointer_rst
    && clock_control_r == clock_control_rst)
    else $error("register not at reset value");

endmodule // cpu_dual_pointer_sfr
`default_nettype wire

// file: core/phase_counter.sv
`timescale 1ns/1ps
`default_nettype none
module phase_counter
  import sfr_timing_pkg::*;
(
  mclk,
  rst_n,
  cycle_end
);
  input wire logic mclk;
  input wire logic rst_n;
  output logic cycle_end;

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  assign phase_nxt = phase_r + 2'h1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
      cycle_end <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cycle_end <= (phase_r == 2'(cycle_clocks - 2));
    end
  end

  a_phase_period: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(cycle_end) |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
endmodule // phase_counter
`default_nettype wire

// file: core/sfr_timing_pkg.sv
package sfr_timing_pkg;

  localparam logic [7:0] port_zero_latch_addr = 8'h80;
  localparam logic [7:0] stack_top_pointer_addr = 8'h81;
  localparam logic [7:0] pointer_a_low_addr = 8'h82;
  localparam logic [7:0] pointer_a_high_addr = 8'h83;
  localparam logic [7:0] pointer_b_low_addr = 8'h84;
  localparam logic [7:0] pointer_b_high_addr = 8'h85;
  localparam logic [7:0] pointer_select_addr = 8'h86;
  localparam logic [7:0] power_control_addr = 8'h87;
  localparam logic [7:0] timer_control_addr = 8'h88;
  localparam logic [7:0] timer_mode_addr = 8'h89;
  localparam logic [7:0] timer_zero_low_addr = 8'h8a;
  localparam logic [7:0] timer_one_low_addr = 8'h8b;
  localparam logic [7:0] clock_control_addr = 8'h8e;

  localparam logic [7:0] port_zero_latch_rst = 8'hff;
  localparam logic [7:0] stack_top_pointer_rst = 8'h07;
  localparam logic [7:0] pointer_rst = 8'h00;
  localparam logic [7:0] pointer_select_rst = 8'h00;
  localparam logic [7:0] power_control_rst = 8'h30;
  localparam logic [7:0] timer_control_rst = 8'h00;
  localparam logic [7:0] timer_mode_rst = 8'h00;
  localparam logic [7:0] timer_low_rst = 8'h00;
  localparam logic [7:0] clock_control_rst = 8'h01;

  localparam logic [7:0] pointer_select_keep = 8'h01;
  localparam logic [7:0] power_control_keep = 8'hcf;
  localparam logic [7:0] power_control_fixed = 8'h30;

  localparam int stretch_lsb = 0;
  localparam int timer0_speed_bit = 3;
  localparam int timer1_speed_bit = 4;
  localparam int timer2_speed_bit = 5;
  localparam int timer_count = 3;

  localparam int clock_period_ns = 100;
  localparam int cycle_clocks = 4;
  localparam int slow_tick_clocks = 12;
  localparam int fast_tick_clocks = 4;
  localparam int min_instr_cycles = 1;
  localparam int max_instr_cycles = 5;
  localparam int ext_move_base_cycles = 2;
  localparam int data_pointer_read_cycles = 2;
  localparam int direct_move_cycles = 3;
  localparam int product_cycles = 5;

  typedef enum logic [1:0] {
    op_plain,
    op_external_move,
    op_product
  } op_class_t;

endpackage : sfr_timing_pkg

// file: core/timer_tick.sv
`timescale 1ns/1ps
`default_nettype none
module timer_tick
  import sfr_timing_pkg::*;
(
  mclk,
  rst_n,
  fast,
  tick
);
  input wire logic mclk;
  input wire logic rst_n;
  input wire logic fast;
  output logic tick;

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] limit;
  logic [3:0] gap_r;
  logic [3:0] gap_nxt;
  logic seen_r;
  logic slow_hold_r;
  logic slow_hold_nxt;

  // Changing speed mid-count stretches one period when slowing and cuts it short when speeding up, never loses a tick.
  assign limit = fast ? 4'(fast_tick_clocks - 1) : 4'(slow_tick_clocks - 1);
  assign cnt_nxt = (cnt_r >= limit) ? 4'h0 : cnt_r + 4'h1;

  // A gap is only judged when fast stayed low since the last tick, so a speed change never trips it.
  assign gap_nxt = tick ? 4'h0 : ((gap_r == 4'hf) ? gap_r : gap_r + 4'h1);
  assign slow_hold_nxt = tick ? !fast : (slow_hold_r && !fast);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= 4'h0;
      seen_r <= 1'b0;
      slow_hold_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_r | tick;
      slow_hold_r <= slow_hold_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= (cnt_r >= limit);
    end
  end

  a_slow_tick_gap: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && seen_r && slow_hold_r |-> gap_r == 4'(slow_tick_clocks - 1))
    else $error("slow timer tick is not twelve clocks apart");
endmodule // timer_tick
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfr_timing_pkg::*;
  logic mclk, rst_n, sfr_wr, sfr_rd, op_start, op_class_ext, op_class_prod;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, w;
  logic [2:0] op_bytes, timer_tick_out;
  logic [15:0] data_pointer, pa, pb;
  logic op_done, op_busy;
  int mismatches, checks_done, cycles, seed, n;

  cpu_dual_pointer_sfr i_dut (
    .mclk(mclk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .op_start(op_start),
    .op_bytes(op_bytes), .op_class_ext(op_class_ext), .op_class_prod(op_class_prod),
    .sfr_rdata(sfr_rdata), .data_pointer(data_pointer), .op_done(op_done),
    .op_busy(op_busy), .timer_tick_out(timer_tick_out)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hung handshake must not stall the run, so a cycle ceiling ends it.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] rst_exp(input logic [7:0] a);
    case (a)
      port_zero_latch_addr: return port_zero_latch_rst;
      stack_top_pointer_addr: return stack_top_pointer_rst;
      power_control_addr: return power_control_rst;
      clock_control_addr: return clock_control_rst;
      default: return 8'h00;
    endcase
  endfunction

  function automatic int op_exp(input logic [2:0] b, input logic e, input logic p, input int s);
    if (p) return product_cycles;
    if (e) return (ext_move_base_cycles + s > 5) ? 5 : ext_move_base_cycles + s;
    return (b == 3'h0) ? 1 : (b > 3'h5) ? 5 : int'(b);
  endfunction

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    d = sfr_rdata;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  task automatic check_resets();
    logic [7:0] a;
    for (int i = 0; i < 13; i++) begin
      a = (i == 12) ? clock_control_addr : 8'h80 + 8'(i);
      sfr_read(a, rd);
      check(rd, rst_exp(a));
    end
    check(data_pointer, 16'h0000);
  endtask

  // Busy is counted at falling edges, so the figure is in whole clocks.
  task automatic run_op(input logic [2:0] b, input logic e, input logic p, input int cyc);
    int k;
    logic dn;
    k = 0;
    dn = 1'b0;
    @(posedge mclk);
    op_bytes <= b;
    op_class_ext <= e;
    op_class_prod <= p;
    op_start <= 1'b1;
    @(negedge mclk);
    while (op_busy !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    k = 0;
    while (op_busy === 1'b1 && k < 30) begin
      k++;
      @(posedge mclk);
      op_start <= 1'b0;
      @(negedge mclk);
      dn = dn | (op_done === 1'b1);
    end
    check(16'(k), 16'(cycle_clocks * cyc));
    check(16'(dn), 16'h0001);
  endtask

  task automatic tick_gap(input int k, output int g);
    g = 0;
    while (timer_tick_out[k] !== 1'b1 && g < 40) begin
      @(negedge mclk);
      g++;
    end
    g = 0;
    @(negedge mclk);
    while (timer_tick_out[k] !== 1'b1 && g < 40) begin
      g++;
      @(negedge mclk);
    end
    g++;
  endtask

  initial begin
    seed = 99367;
    {rst_n, sfr_wr, sfr_rd, op_start, op_class_ext, op_class_prod} = 6'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    op_bytes = 3'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    check_resets();
    for (int i = 0; i < 3; i++) begin
      pa = (i == 0) ? 16'hffff : 16'($random(seed));
      pb = (i == 0) ? 16'h0000 : 16'($random(seed));
      sfr_write(pointer_a_low_addr, pa[7:0]);
      sfr_write(pointer_a_high_addr, pa[15:8]);
      sfr_write(pointer_b_low_addr, pb[7:0]);
      sfr_write(pointer_b_high_addr, pb[15:8]);
      sfr_read(pointer_b_high_addr, rd);
      check(rd, pb[15:8]);
      sfr_write(pointer_select_addr, 8'h00);
      // The pointer follows the select one clock late, so look at a falling edge.
      @(posedge mclk);
      @(negedge mclk);
      check(data_pointer, pa);
      sfr_write(pointer_select_addr, 8'hfe | 8'(i));
      sfr_read(pointer_select_addr, rd);
      check(rd, 8'(i & 1));
      for (int t = 0; t < 2; t++) begin
        sfr_read(pointer_select_addr, rd);
        sfr_write(pointer_select_addr, rd + 8'h01);
        @(posedge mclk);
        @(negedge mclk);
        check(data_pointer, (((i + t + 1) & 1) != 0) ? pb : pa);
      end
    end
    for (int i = 0; i < 3; i++) begin
      w = (i == 0) ? 8'h00 : 8'($random(seed));
      sfr_write(power_control_addr, w);
      sfr_read(power_control_addr, rd);
      check(rd, (w & power_control_keep) | power_control_fixed);
    end
    for (int b = 0; b < 8; b++) begin
      run_op(3'(b), 1'b0, 1'b0, op_exp(3'(b), 1'b0, 1'b0, 0));
    end
    run_op(3'h1, 1'b0, 1'b1, product_cycles);
    run_op(3'h1, 1'b1, 1'b0, op_exp(3'h1, 1'b1, 1'b0, 1));
    for (int s = 0; s < 8; s++) begin
      sfr_write(clock_control_addr, 8'(s));
      run_op(3'(s), 1'b1, 1'b0, op_exp(3'(s), 1'b1, 1'b0, s));
    end
    sfr_write(clock_control_addr, clock_control_rst);
    for (int k = 0; k < 3; k++) begin
      tick_gap(k, n);
      check(16'(n), 16'(slow_tick_clocks));
      sfr_write(clock_control_addr, clock_control_rst | (8'h01 << (timer0_speed_bit + k)));
      tick_gap(k, n);
      check(16'(n), 16'(fast_tick_clocks));
      tick_gap((k + 1) % 3, n);
      check(16'(n), 16'(slow_tick_clocks));
      sfr_write(clock_control_addr, clock_control_rst);
    end
    // A reset in mid-run must bring back the same values as power-on.
    sfr_write(stack_top_pointer_addr, 8'h5a);
    sfr_write(pointer_select_addr, 8'h01);
    do_reset();
    check_resets();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
